/* File: pkg/cpu_mode_map.vh */
`ifndef CPU_MODE_MAP_VH
`define CPU_MODE_MAP_VH
// register byte offsets
`define OFS_MAIN_CTRL 8'h00
`define OFS_EXT_CTRL 8'h04
`define OFS_BASE_LO 8'h08
`define OFS_BASE_HI 8'h0C
`define OFS_FEATURE 8'h10
`define OFS_CODE_SEG 8'h14
`define OFS_TASK_REG 8'h18
`define OFS_TASK_SW 8'h1C
`define OFS_STATUS 8'h20
`define OFS_INT_TABLE 8'h24
// register index codes from the decoder
`define IDX_NONE 4'h0
`define IDX_MAIN_CTRL 4'h1
`define IDX_EXT_CTRL 4'h2
`define IDX_BASE_LO 4'h3
`define IDX_BASE_HI 4'h4
`define IDX_FEATURE 4'h5
`define IDX_CODE_SEG 4'h6
`define IDX_TASK_REG 4'h7
`define IDX_TASK_SW 4'h8
`define IDX_STATUS 4'h9
`define IDX_INT_TABLE 4'hA
// field positions
`define BIT_PROT_EN 0
`define BIT_PAGING_EN 31
`define BIT_ADDR_EXT 5
`define BIT_LM_ENABLE 8
`define BIT_LM_ACTIVE 10
`define BIT_CS_LONG 0
`define BIT_CS_DEFAULT 1
`define BIT_TSS_16 16
`define BIT_TSS_BUSY 17
`define BIT_TSS_VALID 18
// reset value of every register
`define RST_ZERO 32'h0000_0000
// fault cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_PG_NO_PE 3'h1
`define CAUSE_NO_ADDR_EXT 3'h2
`define CAUSE_LME_CHANGE 3'h3
`define CAUSE_ADDR_EXT_CLR 3'h4
`define CAUSE_CS_LONG 3'h5
`define CAUSE_TSS_TYPE 3'h6
`define CAUSE_NO_TASK 3'h7
// operand and address size codes
`define SIZE_16 2'h0
`define SIZE_32 2'h1
`define SIZE_64 2'h2
`endif

/* File: hdl/cpu_mode_paging_control.v */
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_mode_map.vh"

module cpu_mode_paging_control (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // translation view
    output reg translation_on,
    output reg long_translation,
    output reg [63:0] translation_base,
    // execution mode view
    output reg mode_64,
    output reg mode_compat,
    output reg cs_reserved,
    output reg [1:0] default_operand_size,
    output reg [1:0] default_address_size,
    output reg gate_as_64,
    output reg legacy_gate_hazard,
    // events
    output reg protection_fault,
    output reg tss_busy_mark,
    output reg tss_save,
    output reg [15:0] tss_selector
);

    // address decode, shared by read mux and write path
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_MAIN_CTRL: reg_index = `IDX_MAIN_CTRL;
                `OFS_EXT_CTRL: reg_index = `IDX_EXT_CTRL;
                `OFS_BASE_LO: reg_index = `IDX_BASE_LO;
                `OFS_BASE_HI: reg_index = `IDX_BASE_HI;
                `OFS_FEATURE: reg_index = `IDX_FEATURE;
                `OFS_CODE_SEG: reg_index = `IDX_CODE_SEG;
                `OFS_TASK_REG: reg_index = `IDX_TASK_REG;
                `OFS_TASK_SW: reg_index = `IDX_TASK_SW;
                `OFS_STATUS: reg_index = `IDX_STATUS;
                `OFS_INT_TABLE: reg_index = `IDX_INT_TABLE;
                default: reg_index = `IDX_NONE;
            endcase
        end
    endfunction

    // architectural state
    reg prot_en_ff; // protection enable
    reg paging_en_ff; // paging enable
    reg addr_ext_ff; // address extension enable
    reg lm_enable_ff; // long mode enable
    reg lm_active_ff; // long mode active
    reg [63:0] base_ff; // table base register
    reg cs_long_ff; // code segment long bit
    reg cs_default_ff; // code segment default-size bit
    reg [15:0] task_sel_ff; // task register selector
    reg tss16_ff; // task segment is the 16-bit kind
    reg tss_busy_ff; // descriptor marked busy
    reg tss_valid_ff; // task register has been loaded
    reg [31:0] int_table_ff; // interrupt table base
    reg idt_legacy_ff; // table still legacy after activation
    reg [2:0] cause_ff; // last fault cause
    reg [7:0] fault_cnt_ff; // faults seen, wraps

    // bus phase signals
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire [3:0] idx = reg_index(paddr);
    wire do_wr = access & pwrite;

    // proposed values from the write data
    wire w_pe = pwdata[`BIT_PROT_EN];
    wire w_pg = pwdata[`BIT_PAGING_EN];
    wire w_ext = pwdata[`BIT_ADDR_EXT];
    wire w_lme = pwdata[`BIT_LM_ENABLE];
    wire activating = lm_enable_ff & ~paging_en_ff & w_pg;

    // consistency check of the write at hand
    reg [2:0] chk_cause;

    // checks depend on bus and state only; state cannot move
    // between setup and access, so both phases see one answer
    always @* begin
        chk_cause = `CAUSE_NONE;
        if (pwrite) begin
            case (idx)
                `IDX_MAIN_CTRL: begin
                    if (w_pg & ~w_pe) begin
                        chk_cause = `CAUSE_PG_NO_PE;
                    end else if (activating & ~addr_ext_ff) begin
                        chk_cause = `CAUSE_NO_ADDR_EXT;
                    end else if (activating & cs_long_ff) begin
                        chk_cause = `CAUSE_CS_LONG;
                    end else if (activating & ~tss16_ff) begin
                        chk_cause = `CAUSE_TSS_TYPE;
                    end
                end
                `IDX_FEATURE: begin
                    // toggling long enable under paging is illegal
                    if (paging_en_ff & (w_lme != lm_enable_ff)) begin
                        chk_cause = `CAUSE_LME_CHANGE;
                    end
                end
                `IDX_EXT_CTRL: begin
                    if (lm_active_ff & ~w_ext) begin
                        chk_cause = `CAUSE_ADDR_EXT_CLR;
                    end
                end
                `IDX_TASK_SW: begin
                    // a switch with no task loaded has nowhere to save
                    if (~tss_valid_ff) begin
                        chk_cause = `CAUSE_NO_TASK;
                    end
                end
                default: begin
                    chk_cause = `CAUSE_NONE;
                end
            endcase
        end
    end

    wire fail = (chk_cause != `CAUSE_NONE);
    wire commit = do_wr & ~fail;

    // mode decode from code segment bits
    reg nxt_m64;
    reg nxt_compat;
    reg nxt_rsv;
    reg [1:0] nxt_osz;
    reg [1:0] nxt_asz;

    // sizes follow the long bit only in long mode; the default bit counts in every mode but 64-bit and the reserved one
    always @* begin
        nxt_m64 = 1'b0;
        nxt_compat = 1'b0;
        nxt_rsv = 1'b0;
        nxt_osz = `SIZE_16;
        nxt_asz = `SIZE_16;
        if (lm_active_ff & cs_long_ff & cs_default_ff) begin
            nxt_rsv = 1'b1;
        end else if (lm_active_ff & cs_long_ff) begin
            nxt_m64 = 1'b1;
            nxt_osz = `SIZE_32;
            nxt_asz = `SIZE_64;
        end else if (lm_active_ff) begin
            nxt_compat = 1'b1;
            nxt_osz = cs_default_ff ? `SIZE_32 : `SIZE_16;
            nxt_asz = cs_default_ff ? `SIZE_32 : `SIZE_16;
        end else begin
            // legacy modes take the default bit as is
            nxt_osz = cs_default_ff ? `SIZE_32 : `SIZE_16;
            nxt_asz = cs_default_ff ? `SIZE_32 : `SIZE_16;
        end
    end

    // read mux, latched in the setup phase
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = `RST_ZERO;
        case (idx)
            `IDX_MAIN_CTRL: begin
                nxt_rdata[`BIT_PROT_EN] = prot_en_ff;
                nxt_rdata[`BIT_PAGING_EN] = paging_en_ff;
            end
            `IDX_EXT_CTRL: begin
                nxt_rdata[`BIT_ADDR_EXT] = addr_ext_ff;
            end
            `IDX_BASE_LO: begin
                nxt_rdata = base_ff[31:0];
            end
            `IDX_BASE_HI: begin
                nxt_rdata = base_ff[63:32];
            end
            `IDX_FEATURE: begin
                nxt_rdata[`BIT_LM_ENABLE] = lm_enable_ff;
                nxt_rdata[`BIT_LM_ACTIVE] = lm_active_ff;
            end
            `IDX_CODE_SEG: begin
                nxt_rdata[`BIT_CS_LONG] = cs_long_ff;
                nxt_rdata[`BIT_CS_DEFAULT] = cs_default_ff;
            end
            `IDX_TASK_REG: begin
                nxt_rdata[15:0] = task_sel_ff;
                nxt_rdata[`BIT_TSS_16] = tss16_ff;
                nxt_rdata[`BIT_TSS_BUSY] = tss_busy_ff;
                nxt_rdata[`BIT_TSS_VALID] = tss_valid_ff;
            end
            `IDX_STATUS: begin
                nxt_rdata[2:0] = cause_ff;
                nxt_rdata[3] = idt_legacy_ff;
                nxt_rdata[15:8] = fault_cnt_ff;
            end
            `IDX_INT_TABLE: begin
                nxt_rdata = int_table_ff;
            end
            default: begin
                nxt_rdata = `RST_ZERO;
            end
        endcase
    end

    // apb handshake: no wait state; every answer is a flop set in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RST_ZERO;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= (idx == `IDX_NONE) | fail;
            prdata <= pwrite ? `RST_ZERO : nxt_rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // control bits and long mode state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_en_ff <= 1'b0;
            paging_en_ff <= 1'b0;
            addr_ext_ff <= 1'b0;
            lm_enable_ff <= 1'b0;
            lm_active_ff <= 1'b0;
        end else if (commit) begin
            case (idx)
                `IDX_MAIN_CTRL: begin
                    // pe and pg may rise in one write
                    prot_en_ff <= w_pe;
                    paging_en_ff <= w_pg;
                    if (activating) begin
                        lm_active_ff <= 1'b1;
                    end else if (paging_en_ff & ~w_pg) begin
                        lm_active_ff <= 1'b0;
                    end
                end
                `IDX_EXT_CTRL: begin
                    addr_ext_ff <= w_ext;
                end
                `IDX_FEATURE: begin
                    // the active bit is read only
                    lm_enable_ff <= w_lme;
                end
                default: begin
                    prot_en_ff <= prot_en_ff;
                end
            endcase
        end
    end

    // table base, code segment and interrupt table
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= {`RST_ZERO, `RST_ZERO};
            cs_long_ff <= 1'b0;
            cs_default_ff <= 1'b0;
            int_table_ff <= `RST_ZERO;
            idt_legacy_ff <= 1'b0;
        end else begin
            if (commit & (idx == `IDX_BASE_LO)) begin
                base_ff[31:0] <= pwdata;
            end
            // upper half only reachable once long mode is active
            if (commit & (idx == `IDX_BASE_HI) & lm_active_ff) begin
                base_ff[63:32] <= pwdata;
            end
            if (commit & (idx == `IDX_CODE_SEG)) begin
                cs_long_ff <= pwdata[`BIT_CS_LONG];
                cs_default_ff <= pwdata[`BIT_CS_DEFAULT];
            end
            // reload ends the legacy window; set wins same cycle
            if (commit & (idx == `IDX_MAIN_CTRL) & activating) begin
                idt_legacy_ff <= 1'b1;
            end else if (commit & (idx == `IDX_INT_TABLE)) begin
                int_table_ff <= pwdata;
                idt_legacy_ff <= 1'b0;
            end else if (~lm_active_ff) begin
                idt_legacy_ff <= 1'b0;
            end
        end
    end

    // task register; activation never touches it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            task_sel_ff <= 16'h0000;
            tss16_ff <= 1'b0;
            tss_busy_ff <= 1'b0;
            tss_valid_ff <= 1'b0;
        end else if (commit & (idx == `IDX_TASK_REG)) begin
            task_sel_ff <= pwdata[15:0];
            tss16_ff <= pwdata[`BIT_TSS_16];
            tss_busy_ff <= 1'b1;
            tss_valid_ff <= 1'b1;
        end
    end

    // event pulses and fault record
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_fault <= 1'b0;
            tss_busy_mark <= 1'b0;
            tss_save <= 1'b0;
            tss_selector <= 16'h0000;
            cause_ff <= `CAUSE_NONE;
            fault_cnt_ff <= 8'h00;
        end else begin
            // fault only after the write was discarded
            protection_fault <= do_wr & fail;
            tss_busy_mark <= commit & (idx == `IDX_TASK_REG);
            tss_save <= commit & (idx == `IDX_TASK_SW);
            if (commit & (idx == `IDX_TASK_REG)) begin
                tss_selector <= pwdata[15:0];
            end else if (commit & (idx == `IDX_TASK_SW)) begin
                tss_selector <= task_sel_ff;
            end
            if (do_wr & fail) begin
                cause_ff <= chk_cause;
                fault_cnt_ff <= fault_cnt_ff + 8'h01;
            end
        end
    end

    // registered views of translation and mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            translation_on <= 1'b0;
            long_translation <= 1'b0;
            translation_base <= {`RST_ZERO, `RST_ZERO};
            mode_64 <= 1'b0;
            mode_compat <= 1'b0;
            cs_reserved <= 1'b0;
            default_operand_size <= `SIZE_16;
            default_address_size <= `SIZE_16;
            gate_as_64 <= 1'b0;
            legacy_gate_hazard <= 1'b0;
        end else begin
            translation_on <= paging_en_ff;
            // base only meaningful while paging is on
            translation_base <= paging_en_ff ? base_ff : 64'h0;
            // entry order is software's duty; we only check it
            long_translation <= paging_en_ff & lm_active_ff;
            mode_64 <= nxt_m64;
            mode_compat <= nxt_compat;
            cs_reserved <= nxt_rsv;
            default_operand_size <= nxt_osz;
            default_address_size <= nxt_asz;
            gate_as_64 <= lm_active_ff;
            legacy_gate_hazard <= idt_legacy_ff;
        end
    end

endmodule // cpu_mode_paging_control
`default_nettype wire

/* File: bench/cpu_mode_paging_control_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_mode_map.vh"
module cpu_mode_paging_control_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // mode and translation views
    input wire logic translation_on,
    input wire logic long_translation,
    input wire logic mode_64,
    input wire logic mode_compat,
    input wire logic cs_reserved,
    input wire logic [1:0] default_operand_size,
    input wire logic [1:0] default_address_size,
    input wire logic gate_as_64,
    // events
    input wire logic protection_fault,
    input wire logic tss_busy_mark
);
    // write at the edge where the slave answers
    wire logic wacc = psel && penable && pready && pwrite;
    // accepted write to the main control word
    wire logic main_ok = wacc && paddr == `OFS_MAIN_CTRL && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    prot_first_a:
    assert property (wacc && paddr == `OFS_MAIN_CTRL && pwdata[31]
        && !pwdata[0] |-> pslverr) else $error("paging without protection");
    paging_off_a:
    assert property (main_ok && !pwdata[31] |-> ##[1:2] !translation_on)
        else $error("translation stays on after paging off");
    // base words never refuse, so low offsets mean a failed check
    fault_follows_a:
    assert property (wacc && pslverr && paddr <= `OFS_FEATURE
        && paddr[1:0] == 2'b00
        |-> ##[1:2] protection_fault) else $error("refused write, no fault");
    fault_pulse_a:
    assert property (protection_fault |=> !protection_fault)
        else $error("fault pulse longer than one cycle");
    sixty_four_a:
    assert property (mode_64 |-> default_operand_size == `SIZE_32
        && default_address_size == `SIZE_64) else $error("64-bit sizes");
    compat_size_a:
    assert property (mode_compat |-> default_operand_size
        == default_address_size && default_operand_size != `SIZE_64)
        else $error("compatibility sizes");
    reserved_cs_a:
    assert property (cs_reserved |-> !mode_64
        && default_operand_size == `SIZE_16) else $error("reserved combo");
    long_xlat_a:
    assert property (long_translation |-> translation_on && gate_as_64)
        else $error("long translation without paging");
    ext_clear_a:
    assert property (wacc && paddr == `OFS_EXT_CTRL && !pwdata[5]
        && gate_as_64 |-> pslverr) else $error("extension cleared in long");
    task_busy_a:
    assert property (wacc && paddr == `OFS_TASK_REG && !pslverr
        |-> ##[1:2] tss_busy_mark) else $error("task load not marked busy");

    // main scenarios reached
    cover property (mode_64);
    cover property (mode_compat);
    cover property (protection_fault);
endmodule // cpu_mode_paging_control_chk

bind cpu_mode_paging_control cpu_mode_paging_control_chk chk_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .translation_on, .long_translation, .mode_64, .mode_compat,
    .cs_reserved, .default_operand_size, .default_address_size,
    .gate_as_64, .protection_fault, .tss_busy_mark
);
`default_nettype wire

/* File: bench/cpu_mode_paging_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_mode_map.vh"
module cpu_mode_paging_control_test;
    // apb master side, changed only just after a rising edge
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    // design outputs
    wire logic [31:0] prdata;
    wire logic [63:0] translation_base;
    wire logic [1:0] default_operand_size, default_address_size;
    wire logic [15:0] tss_selector;
    wire logic pready, pslverr, translation_on, long_translation, mode_64;
    wire logic mode_compat, cs_reserved, gate_as_64, legacy_gate_hazard;
    wire logic protection_fault, tss_busy_mark, tss_save;
    // read data and error taken at the answer edge
    logic [31:0] rd;
    logic er;
    // pulse tallies: pulses are too short to poll from the tasks
    int n_fault = 0;
    int n_busy = 0;
    int n_save = 0;
    int fail_count = 0;
    int n_tests = 0;

    cpu_mode_paging_control DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .translation_on, .long_translation,
        .translation_base, .mode_64, .mode_compat, .cs_reserved,
        .default_operand_size, .default_address_size, .gate_as_64,
        .legacy_gate_hazard, .protection_fault, .tss_busy_mark, .tss_save,
        .tss_selector
    );

    // 50 MHz clock
    always #10 pclk = ~pclk;

    // count event pulses; nonblocking so task reads never race
    always @(posedge pclk) begin
        if (protection_fault === 1'b1) n_fault <= n_fault + 1;
        if (tss_busy_mark === 1'b1) n_busy <= n_busy + 1;
        if (tss_save === 1'b1) n_save <= n_save + 1;
    end

    // compare and tally
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer: setup, access held until pready, then release
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the hang guard ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // views lag a cycle; let them and the pulses land
        repeat (3) @(posedge pclk);
    endtask

    task automatic t_reset;
        chk(translation_on, 1'b0);
        chk(translation_base, 64'h0);
        apb(1'b0, `OFS_FEATURE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'h0000_0001);
        chk(er, 1'b1);
        chk(n_fault, 0);
        $display("test reset done");
    endtask

    task automatic t_paging;
        apb(1'b1, `OFS_BASE_LO, 32'h0012_3000);
        apb(1'b1, `OFS_BASE_HI, 32'h0000_0007);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0000);
        chk(er, 1'b1);
        chk(n_fault, 1);
        chk(translation_on, 1'b0);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0001);
        chk(er, 1'b0);
        chk(translation_on, 1'b1);
        chk(translation_base, 64'h0000_0000_0012_3000);
        $display("test paging done");
    endtask

    // every failing activation check, then a clean activation
    task automatic t_entry;
        apb(1'b1, `OFS_FEATURE, 32'h0000_0100);
        chk(er, 1'b1);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h0000_0001);
        apb(1'b1, `OFS_FEATURE, 32'h0000_0100);
        chk(er, 1'b0);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0001);
        chk(er, 1'b1);
        apb(1'b1, `OFS_EXT_CTRL, 32'h0000_0020);
        apb(1'b1, `OFS_CODE_SEG, 32'h0000_0001);
        apb(1'b1, `OFS_TASK_REG, 32'h0001_0028);
        chk(n_busy, 1);
        chk(n_save, 0);
        chk(tss_selector, 16'h0028);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0001);
        chk(er, 1'b1);
        apb(1'b1, `OFS_CODE_SEG, 32'h0000_0000);
        apb(1'b1, `OFS_TASK_REG, 32'h0000_0030);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0001);
        chk(er, 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk(rd[2:0], `CAUSE_TSS_TYPE);
        chk(rd[15:8], 8'h05);
        chk(translation_on, 1'b0);
        apb(1'b1, `OFS_TASK_REG, 32'h0001_0028);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h8000_0001);
        chk(er, 1'b0);
        apb(1'b0, `OFS_FEATURE, 32'h0000_0000);
        chk(rd[10], 1'b1);
        chk(long_translation, 1'b1);
        chk(legacy_gate_hazard, 1'b1);
        apb(1'b0, `OFS_TASK_REG, 32'h0000_0000);
        chk(rd[17:0], 18'h3_0028);
        $display("test entry done");
    endtask

    // code segment decode, {m64, compat, rsv, op, addr} per value
    task automatic t_long;
        logic [6:0] m [4] = '{7'h20, 7'h46, 7'h25, 7'h10};
        apb(1'b1, `OFS_EXT_CTRL, 32'h0000_0000);
        chk(er, 1'b1);
        chk(n_fault, 6);
        apb(1'b1, `OFS_BASE_HI, 32'h0000_0009);
        chk(translation_base[63:32], 32'h0000_0009);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_CODE_SEG, 32'(i));
            chk({cs_reserved, default_operand_size, default_address_size},
                m[i][4:0]);
            if (i < 3) chk({mode_64, mode_compat}, m[i][6:5]);
            if (i == 0) chk(long_translation, 1'b1);
        end
        apb(1'b1, `OFS_INT_TABLE, 32'h0000_1000);
        chk(legacy_gate_hazard, 1'b0);
        apb(1'b1, `OFS_TASK_SW, 32'h0000_0000);
        chk(n_save, 1);
        $display("test long done");
    endtask

    task automatic t_exit;
        apb(1'b1, `OFS_CODE_SEG, 32'h0000_0000);
        apb(1'b1, `OFS_MAIN_CTRL, 32'h0000_0001);
        chk(er, 1'b0);
        apb(1'b0, `OFS_FEATURE, 32'h0000_0000);
        chk(rd[10], 1'b0);
        chk({gate_as_64, mode_compat, translation_on}, 3'h0);
        apb(1'b1, `OFS_FEATURE, 32'h0000_0000);
        chk(er, 1'b0);
        $display("test exit done");
    endtask

    // reset in mid-run with long enable set, then a switch with no task
    task automatic t_rearm;
        apb(1'b1, `OFS_FEATURE, 32'h0000_0100);
        chk(er, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(translation_on, 1'b0);
        apb(1'b0, `OFS_FEATURE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, `OFS_TASK_SW, 32'h0000_0000);
        chk(er, 1'b1);
        chk(n_save, 1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk(rd[15:0], 16'h0107);
        $display("test rearm done");
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence after a 20 cycle reset
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_paging();
        t_entry();
        t_long();
        t_exit();
        t_rearm();
        give_verdict();
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #400_000;
        fail_count++;
        give_verdict();
    end
endmodule // cpu_mode_paging_control_test
`default_nettype wire
